/* File: hw/fcs_pkg.sv */
// constants, types and helpers for the flash command sequencer
// assumes a 100 MHz system clock and a x16 parallel flash behind the pins
`default_nettype none

package fcs_pkg;

	localparam int CLK_MHZ = 100;

	function automatic int fcs_ceil_div(input int num, input int den);
		return (num + den - 1) / den;
	endfunction : fcs_ceil_div

	// pin timing, times in ns, tick length in clock cycles, other counts in divider ticks
	localparam int T_TICK_NS = 20;
	localparam int TICK_CYCLES = fcs_ceil_div(T_TICK_NS * CLK_MHZ, 1000);
	localparam int T_SETUP_NS = 20;
	localparam int T_STROBE_WR_NS = 60;
	localparam int T_STROBE_RD_NS = 80;
	localparam int T_HOLD_NS = 20;
	localparam int SETUP_TICKS = fcs_ceil_div(T_SETUP_NS, T_TICK_NS);
	localparam int STROBE_WR_TICKS = fcs_ceil_div(T_STROBE_WR_NS, T_TICK_NS);
	localparam int STROBE_RD_TICKS = fcs_ceil_div(T_STROBE_RD_NS, T_TICK_NS);
	localparam int HOLD_TICKS = fcs_ceil_div(T_HOLD_NS, T_TICK_NS);

	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int BUF_DEPTH = 16;
	localparam int BUF_IDX_W = 4;
	localparam int PADDR_W = 12;

	// device command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_BANK_ERASE = 8'h30;
	localparam logic [7:0] CMD_WORD_WRITE = 8'h40;
	localparam logic [7:0] CMD_WORD_WRITE_ALT = 8'h10;
	localparam logic [7:0] CMD_BUF_WRITE = 8'hE8;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;

	// status and extended status fields
	localparam int STAT_READY_BIT = 7;
	localparam int STAT_ERASE_ERR_BIT = 5;
	localparam int STAT_WRITE_ERR_BIT = 4;
	localparam logic [7:0] EXT_AVAIL_MASK = 8'h80;

	// software register offsets and fields
	localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [PADDR_W-1:0] REG_ADDR = 12'h004;
	localparam logic [PADDR_W-1:0] REG_WDATA = 12'h008;
	localparam logic [PADDR_W-1:0] REG_COUNT = 12'h00C;
	localparam logic [PADDR_W-1:0] REG_STATUS = 12'h010;
	localparam logic [PADDR_W-1:0] REG_RDATA = 12'h014;
	localparam logic [5:0] REG_BUF_PAGE = 6'h01;
	localparam int CTRL_ALT_BIT = 3;
	localparam int CTRL_GO_BIT = 8;

	typedef enum logic [2:0] {
		OP_READ_ARRAY = 3'h0,
		OP_READ_STATUS = 3'h1,
		OP_CLEAR_STATUS = 3'h2,
		OP_BLOCK_ERASE = 3'h3,
		OP_BANK_ERASE = 3'h4,
		OP_WORD_WRITE = 3'h5,
		OP_BUF_WRITE = 3'h6,
		OP_LOCK_SET = 3'h7
	} fcs_op_e;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcs_pin_req_s;

	function automatic fcs_pin_req_s fcs_word(input logic write, input logic [ADDR_W-1:0] addr,
			input logic [DATA_W-1:0] data);
		fcs_pin_req_s r;
		r.write = write;
		r.addr = addr;
		r.data = data;
		return r;
	endfunction : fcs_word

	function automatic logic [DATA_W-1:0] fcs_cmd(input logic [7:0] code);
		return {8'h00, code};
	endfunction : fcs_cmd

endpackage : fcs_pkg

`default_nettype wire

/* File: hw/fcs_tick_div.sv */
// divider giving a one-cycle tick that paces the flash pin cycles
// assumes a single clock domain
`default_nettype none

module fcs_tick_div
	import fcs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	output logic o_tick
);

	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_cnt = cnt + 8'h01;
		if (cnt == 8'(TICK_CYCLES - 1)) begin
			next_cnt = 8'h00;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 8'h00;
			o_tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			o_tick <= next_tick;
		end
	end

endmodule : fcs_tick_div

`default_nettype wire

/* File: hw/fcs_pin_cycle.sv */
// one asynchronous flash bus cycle, read or write, on the device pins
// assumes a request only while idle and synchronous data inputs
`default_nettype none

module fcs_pin_cycle
	import fcs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic i_req,
	input wire fcs_pin_req_s i_cmd,
	input wire logic [DATA_W-1:0] i_dq_in,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq_out,
	output logic o_dq_oe,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n
);

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_SETUP = 4'b0010,
		PH_STROBE = 4'b0100,
		PH_HOLD = 4'b1000
	} fcs_phase_e;

	fcs_phase_e ph, next_ph;
	logic wr, next_wr;
	logic [3:0] cnt, next_cnt;
	logic next_done;
	logic [DATA_W-1:0] next_rdata;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_dq_out;
	logic next_dq_oe, next_ce_n, next_we_n, next_oe_n;

	always_comb begin
		next_ph = ph;
		next_wr = wr;
		next_cnt = cnt;
		next_done = 1'b0;
		next_rdata = o_rdata;
		next_addr = o_addr;
		next_dq_out = o_dq_out;
		next_dq_oe = o_dq_oe;
		next_ce_n = o_ce_n;
		next_we_n = o_we_n;
		next_oe_n = o_oe_n;
		case (ph)
			PH_IDLE: begin
				if (i_req) begin
					next_ph = PH_SETUP;
					next_wr = i_cmd.write;
					next_addr = i_cmd.addr;
					next_dq_out = i_cmd.data;
					next_dq_oe = i_cmd.write;
					next_ce_n = 1'b0;
					next_cnt = 4'(SETUP_TICKS);
				end
			end
			PH_SETUP: begin
				if (i_tick) begin
					next_cnt = cnt - 4'h1;
					if (cnt == 4'h1) begin
						next_ph = PH_STROBE;
						next_we_n = !wr;
						next_oe_n = wr;
						next_cnt = wr ? 4'(STROBE_WR_TICKS) : 4'(STROBE_RD_TICKS);
					end
				end
			end
			PH_STROBE: begin
				if (i_tick) begin
					next_cnt = cnt - 4'h1;
					if (cnt == 4'h1) begin
						next_ph = PH_HOLD;
						next_we_n = 1'b1;
						next_oe_n = 1'b1;
						next_cnt = 4'(HOLD_TICKS);
						if (!wr) begin
							next_rdata = i_dq_in;
						end
					end
				end
			end
			PH_HOLD: begin
				if (i_tick) begin
					next_cnt = cnt - 4'h1;
					if (cnt == 4'h1) begin
						next_ph = PH_IDLE;
						next_ce_n = 1'b1;
						next_dq_oe = 1'b0;
						next_done = 1'b1;
					end
				end
			end
			default: begin
				next_ph = PH_IDLE;
				next_ce_n = 1'b1;
				next_we_n = 1'b1;
				next_oe_n = 1'b1;
				next_dq_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ph <= PH_IDLE;
			wr <= 1'b0;
			cnt <= 4'h0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_addr <= 21'h00_0000;
			o_dq_out <= 16'h0000;
			o_dq_oe <= 1'b0;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
		end else begin
			ph <= next_ph;
			wr <= next_wr;
			cnt <= next_cnt;
			o_done <= next_done;
			o_rdata <= next_rdata;
			o_addr <= next_addr;
			o_dq_out <= next_dq_out;
			o_dq_oe <= next_dq_oe;
			o_ce_n <= next_ce_n;
			o_we_n <= next_we_n;
			o_oe_n <= next_oe_n;
		end
	end

endmodule : fcs_pin_cycle

`default_nettype wire

/* File: hw/fcs_sequencer.sv */
// host-side command sequencer for a parallel flash, with an apb register file
// assumes apb3 master on i_mclk and the flash pins wired to the o_flash ports
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none

module fcs_sequencer
	import fcs_pkg::*;
#(
	parameter logic [7:0] P_CMD_CLEAR_STATUS = 8'h00
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [PADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic [DATA_W-1:0] o_flash_dq_out,
	output logic o_flash_dq_oe,
	input wire logic [DATA_W-1:0] i_flash_dq_in,
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n,
	output logic o_busy
);

	typedef enum logic [12:0] {
		ST_IDLE = 13'b0_0000_0000_0001,
		ST_PRE_CMD = 13'b0_0000_0000_0010,
		ST_PRE_POLL = 13'b0_0000_0000_0100,
		ST_SETUP = 13'b0_0000_0000_1000,
		ST_SECOND = 13'b0_0000_0001_0000,
		ST_EXT_READ = 13'b0_0000_0010_0000,
		ST_COUNT_WR = 13'b0_0000_0100_0000,
		ST_DATA_WR = 13'b0_0000_1000_0000,
		ST_CONFIRM = 13'b0_0001_0000_0000,
		ST_POLL = 13'b0_0010_0000_0000,
		ST_CLEAR = 13'b0_0100_0000_0000,
		ST_ARRAY = 13'b0_1000_0000_0000,
		ST_ARRAY_READ = 13'b1_0000_0000_0000
	} fcs_state_e;

	logic tick;
	logic pin_req;
	fcs_pin_req_s pin_cmd;
	logic pin_done;
	logic [DATA_W-1:0] pin_rdata;

	fcs_tick_div u_div (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.o_tick(tick)
	);

	fcs_pin_cycle u_pin (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_tick(tick),
		.i_req(pin_req),
		.i_cmd(pin_cmd),
		.i_dq_in(i_flash_dq_in),
		.o_done(pin_done),
		.o_rdata(pin_rdata),
		.o_addr(o_flash_addr),
		.o_dq_out(o_flash_dq_out),
		.o_dq_oe(o_flash_dq_oe),
		.o_ce_n(o_flash_ce_n),
		.o_we_n(o_flash_we_n),
		.o_oe_n(o_flash_oe_n)
	);

	// apb register group
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] wdata, next_wdata;
	logic [BUF_IDX_W-1:0] count, next_count;
	logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_en, buf_hit, apb_go;

	// sequencer group
	fcs_state_e state, next_state;
	logic issued, next_issued;
	fcs_op_e op, next_op;
	logic alt, next_alt;
	logic [BUF_IDX_W-1:0] idx, next_idx;
	logic [7:0] last_stat, next_stat;
	logic [7:0] last_ext, next_ext;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic done, next_done;
	logic auto_clr, next_auto_clr;
	logic next_busy;

	assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
	assign buf_hit = (i_paddr[11:6] == REG_BUF_PAGE);
	assign apb_go = wr_en && (i_paddr == REG_CTRL) && i_pwdata[CTRL_GO_BIT];

	always_comb begin
		next_pready = i_psel && i_penable && !o_pready;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		next_addr = addr;
		next_wdata = wdata;
		next_count = count;
		if (i_psel && i_penable && !o_pready) begin
			if (buf_hit) begin
				next_prdata = {16'h0000, buf_mem[i_paddr[5:2]]};
			end else begin
				case (i_paddr)
					REG_CTRL: next_prdata = {28'h000_0000, alt, op};
					REG_ADDR: next_prdata = {11'h000, addr};
					REG_WDATA: next_prdata = {16'h0000, wdata};
					REG_COUNT: next_prdata = {28'h000_0000, count};
					REG_STATUS: next_prdata = {last_ext, 7'h00, auto_clr, last_stat, 6'h00, done, o_busy};
					REG_RDATA: next_prdata = {16'h0000, rdata};
					default: next_pslverr = 1'b1;
				endcase
			end
		end
		if (wr_en && !o_busy) begin
			case (i_paddr)
				REG_ADDR: next_addr = i_pwdata[ADDR_W-1:0];
				REG_WDATA: next_wdata = i_pwdata[DATA_W-1:0];
				REG_COUNT: next_count = i_pwdata[BUF_IDX_W-1:0];
				default: next_count = count;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
			addr <= 21'h00_0000;
			wdata <= 16'h0000;
			count <= 4'h0;
		end else begin
			o_pready <= next_pready;
			o_prdata <= next_prdata;
			o_pslverr <= next_pslverr;
			addr <= next_addr;
			wdata <= next_wdata;
			count <= next_count;
		end
	end

	// write buffer, loaded by software before a buffered write
	always_ff @(posedge i_mclk) begin
		if (wr_en && buf_hit && !o_busy) begin
			buf_mem[i_paddr[5:2]] <= i_pwdata[DATA_W-1:0];
		end
	end

	always_comb begin
		next_state = state;
		next_issued = issued;
		next_op = op;
		next_alt = alt;
		next_idx = idx;
		next_stat = last_stat;
		next_ext = last_ext;
		next_rdata = rdata;
		next_done = done;
		next_auto_clr = auto_clr;
		next_busy = o_busy;
		pin_req = 1'b0;
		pin_cmd = fcs_word(1'b0, addr, 16'h0000);
		// word placed on the pins in each state
		case (state)
			ST_PRE_CMD: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_READ_STATUS));
			ST_SETUP: begin
				case (op)
					OP_BLOCK_ERASE: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_BLOCK_ERASE));
					OP_BANK_ERASE: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_BANK_ERASE));
					OP_WORD_WRITE: pin_cmd = fcs_word(1'b1, addr,
						fcs_cmd(alt ? CMD_WORD_WRITE_ALT : CMD_WORD_WRITE));
					OP_BUF_WRITE: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_BUF_WRITE));
					default: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_LOCK_SETUP));
				endcase
			end
			ST_SECOND: begin
				case (op)
					OP_WORD_WRITE: pin_cmd = fcs_word(1'b1, addr, wdata);
					OP_LOCK_SET: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_LOCK_CONFIRM));
					default: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_CONFIRM));
				endcase
			end
			ST_COUNT_WR: pin_cmd = fcs_word(1'b1, addr, {12'h000, count});
			ST_DATA_WR: pin_cmd = fcs_word(1'b1, addr + {17'h0_0000, idx}, buf_mem[idx]);
			ST_CONFIRM: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_CONFIRM));
			ST_CLEAR: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(P_CMD_CLEAR_STATUS));
			ST_ARRAY: pin_cmd = fcs_word(1'b1, addr, fcs_cmd(CMD_READ_ARRAY));
			default: pin_cmd = fcs_word(1'b0, addr, 16'h0000);
		endcase
		if (state != ST_IDLE) begin
			pin_req = !issued;
			next_issued = 1'b1;
			if (pin_done) begin
				next_issued = 1'b0;
			end
		end
		case (state)
			ST_IDLE: begin
				if (apb_go) begin
					next_op = fcs_op_e'(i_pwdata[2:0]);
					next_alt = i_pwdata[CTRL_ALT_BIT];
					next_done = 1'b0;
					next_auto_clr = 1'b0;
					next_busy = 1'b1;
					next_state = ST_PRE_CMD;
				end
			end
			ST_PRE_CMD: begin
				if (pin_done) begin
					next_state = ST_PRE_POLL;
				end
			end
			ST_PRE_POLL: begin
				if (pin_done) begin
					next_stat = pin_rdata[7:0];
					if (pin_rdata[STAT_READY_BIT]) begin
						case (op)
							OP_READ_ARRAY: next_state = ST_ARRAY;
							OP_READ_STATUS: begin
								next_busy = 1'b0;
								next_done = 1'b1;
								next_state = ST_IDLE;
							end
							OP_CLEAR_STATUS: next_state = ST_CLEAR;
							default: next_state = ST_SETUP;
						endcase
					end
				end
			end
			ST_SETUP: begin
				if (pin_done) begin
					next_state = (op == OP_BUF_WRITE) ? ST_EXT_READ : ST_SECOND;
				end
			end
			ST_SECOND: begin
				if (pin_done) begin
					next_state = ST_POLL;
				end
			end
			ST_EXT_READ: begin
				if (pin_done) begin
					next_ext = pin_rdata[7:0] & EXT_AVAIL_MASK;
					if ((pin_rdata[7:0] & EXT_AVAIL_MASK) != 8'h00) begin
						next_state = ST_COUNT_WR;
					end else begin
						next_state = ST_SETUP;
					end
				end
			end
			ST_COUNT_WR: begin
				if (pin_done) begin
					next_idx = 4'h0;
					next_state = ST_DATA_WR;
				end
			end
			ST_DATA_WR: begin
				if (pin_done) begin
					next_idx = idx + 4'h1;
					if (idx == count) begin
						next_state = ST_CONFIRM;
					end
				end
			end
			ST_CONFIRM: begin
				if (pin_done) begin
					next_state = ST_POLL;
				end
			end
			ST_POLL: begin
				if (pin_done) begin
					next_stat = pin_rdata[7:0];
					if (pin_rdata[STAT_READY_BIT]) begin
						next_state = ST_ARRAY;
						if (op == OP_BUF_WRITE && pin_rdata[STAT_ERASE_ERR_BIT]
								&& pin_rdata[STAT_WRITE_ERR_BIT]) begin
							next_auto_clr = 1'b1;
							next_state = ST_CLEAR;
						end
					end
				end
			end
			ST_CLEAR: begin
				if (pin_done) begin
					next_state = ST_ARRAY;
				end
			end
			ST_ARRAY: begin
				if (pin_done) begin
					if (op == OP_READ_ARRAY) begin
						next_state = ST_ARRAY_READ;
					end else begin
						next_busy = 1'b0;
						next_done = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_ARRAY_READ: begin
				if (pin_done) begin
					next_rdata = pin_rdata;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_busy = 1'b0;
				next_issued = 1'b0;
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			issued <= 1'b0;
			op <= OP_READ_ARRAY;
			alt <= 1'b0;
			idx <= 4'h0;
			last_stat <= 8'h00;
			last_ext <= 8'h00;
			rdata <= 16'h0000;
			done <= 1'b0;
			auto_clr <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			state <= next_state;
			issued <= next_issued;
			op <= next_op;
			alt <= next_alt;
			idx <= next_idx;
			last_stat <= next_stat;
			last_ext <= next_ext;
			rdata <= next_rdata;
			done <= next_done;
			auto_clr <= next_auto_clr;
			o_busy <= next_busy;
		end
	end

endmodule : fcs_sequencer

`default_nettype wire

/* File: bench/fcs_flash_model.sv */
// behavioural parallel flash answering the sequencer's pin cycles
// assumes writes are taken at the rising write strobe while chip enable is low
`default_nettype none

module fcs_flash_model #(
	parameter logic [7:0] P_CLR = 8'h5A,
	parameter int P_BUSY = 40
) (
	input wire logic i_mclk,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [20:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_vpp_bad,
	input wire logic i_fail,
	output logic [15:0] o_dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	logic [15:0] bdat [16];
	logic [7:0] badr [16];
	logic [31:0] locked = '0;
	logic [7:0] stat = 8'h80;
	logic [7:0] pend = 8'h00;
	logic [1:0] mode = 2'h0;
	logic [15:0] rd;
	logic [15:0] last = 16'h0000;
	logic we_d = 1'b1;
	logic avail = 1'b0;
	logic abort = 1'b0;
	logic [20:0] base = '0;
	int busy = 0;
	int left = 0;
	int n = 0;
	int skip = 1;

	initial foreach (mem[i]) mem[i] = 16'hFFFF;

	always_comb begin
		case (mode)
			2'h0: rd = mem[i_addr[7:0]];
			2'h1: rd = {8'h00, busy == 0, stat[6:0]};
			default: rd = {8'h00, avail, 7'h7F};
		endcase
	end
	// released bus shows the inverse of the last value
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;

	task automatic start(input logic er, input logic prot, output logic go);
		go = 1'b0;
		busy = P_BUSY;
		if (i_vpp_bad) begin
			stat[3] = 1'b1;
			stat[er ? 5 : 4] = 1'b1;
		end else if (prot) stat[1] = 1'b1;
		else if (i_fail) stat[er ? 5 : 4] = 1'b1;
		else go = 1'b1;
	endtask : start

	always @(posedge i_mclk) begin : take
		logic [7:0] c;
		logic go;
		c = i_dq[7:0];
		if (busy > 0) busy = busy - 1;
		if (!i_ce_n && !i_oe_n) last = rd;
		if (i_we_n && !we_d && !i_ce_n) begin
			mode = 2'h1;
			if (pend == 8'h40 || pend == 8'h10) begin
				start(1'b0, locked[i_addr[20:16]], go);
				if (go) mem[i_addr[7:0]] = mem[i_addr[7:0]] & i_dq;
				pend = 8'h00;
			end else if (pend == 8'hE9 && n < left) begin
				if (i_addr[20:16] != base[20:16]) abort = 1'b1;
				badr[n] = i_addr[7:0];
				bdat[n] = i_dq;
				n++;
			end else if (pend == 8'hE9) begin
				if (c != 8'hD0 || abort) stat[5:4] = 2'h3;
				else begin
					start(1'b0, locked[base[20:16]], go);
					for (int i = 0; i < left; i++) if (go) mem[badr[i]] = bdat[i];
				end
				pend = 8'h00;
				skip = 1;
			end else if (pend == 8'hE8) begin
				left = c + 1;
				n = 0;
				abort = 1'b0;
				pend = 8'hE9;
			end else if (pend != 8'h00) begin
				if (c != (pend == 8'h60 ? 8'h01 : 8'hD0)) stat[5:4] = 2'h3;
				else begin
					start(pend != 8'h60, pend == 8'h20 && locked[i_addr[20:16]], go);
					if (go && pend == 8'h60) locked[i_addr[20:16]] = 1'b1;
					else if (go) foreach (mem[i]) mem[i] = 16'hFFFF;
				end
				pend = 8'h00;
			end else begin
				case (c)
					8'hFF: mode = 2'h0;
					P_CLR: stat[5:1] = 5'h00;
					8'hE8: begin
						mode = 2'h2;
						avail = skip == 0;
						skip = 0;
						if (avail) pend = c;
						base = i_addr;
					end
					8'h20, 8'h30, 8'h40, 8'h10, 8'h60: pend = c;
					default: ;
				endcase
			end
		end
		we_d = i_we_n;
	end
endmodule : fcs_flash_model

`default_nettype wire

/* File: bench/fcs_sequencer_monitor.sv */
// concurrent checks on the sequencer's apb and flash pin ports
// assumes one clock domain with an asynchronous active high reset
`default_nettype none

module fcs_sequencer_monitor
	import fcs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [PADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [ADDR_W-1:0] o_flash_addr,
	input wire logic [DATA_W-1:0] o_flash_dq_out,
	input wire logic o_flash_dq_oe,
	input wire logic [DATA_W-1:0] i_flash_dq_in,
	input wire logic o_flash_ce_n,
	input wire logic o_flash_we_n,
	input wire logic o_flash_oe_n,
	input wire logic o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic we_d, oe_d, rd7, next_rd7, rdy, next_rdy;
	logic [3:0] wcnt, next_wcnt;
	logic [7:0] op, next_op, lastw, next_lastw;
	logic [ADDR_W-1:0] opa, next_opa;
	wire logic wr = o_flash_we_n & ~we_d;
	wire logic [7:0] d = o_flash_dq_out[7:0];

	// write count within an operation, its opcode and last ready poll
	always_comb begin
		next_wcnt = o_busy ? wcnt + {3'h0, wr & ~&wcnt} : 4'h0;
		next_op = (wr && wcnt == 4'h1) ? d : op;
		next_opa = (wr && wcnt == 4'h1) ? o_flash_addr : opa;
		next_lastw = wr ? d : lastw;
		next_rd7 = o_flash_oe_n ? rd7 : i_flash_dq_in[7];
		next_rdy = wr ? 1'b0 : (o_flash_oe_n && !oe_d) ? rd7 : rdy;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{we_d, oe_d, rd7, rdy} <= 4'hC;
			{wcnt, op, lastw, opa} <= '0;
		end else begin
			{we_d, oe_d, rd7, rdy} <= {o_flash_we_n, o_flash_oe_n, next_rd7, next_rdy};
			{wcnt, op, lastw, opa} <= {next_wcnt, next_op, next_lastw, next_opa};
		end
	end

	sequence s_one_wait;
		!o_pready ##1 o_pready;
	endsequence
	a_apb_wait: assert property ($rose(i_penable) && i_psel |-> s_one_wait)
		else $error("pready not one cycle after access start");
	a_status_first: assert property (wr && wcnt == 4'h0 |-> d == CMD_READ_STATUS)
		else $error("operation did not open with status command");
	a_ready_first: assert property (wr && wcnt == 4'h1 |-> rdy)
		else $error("command issued without a ready poll");
	a_erase_pair: assert property (wr && wcnt == 4'h2 && (op == 8'h20 || op == 8'h30)
		|-> d == CMD_CONFIRM && (op == 8'h30 || o_flash_addr[20:16] == opa[20:16]))
		else $error("erase confirm wrong");
	a_lock_pair: assert property (wr && wcnt == 4'h2 && op == CMD_LOCK_SETUP |->
		d == CMD_LOCK_CONFIRM && o_flash_addr[20:16] == opa[20:16])
		else $error("lock confirm wrong");
	a_word_target: assert property (wr && wcnt == 4'h2 && (op == 8'h40 || op == 8'h10) |->
		o_flash_addr == opa)
		else $error("word data sent to another location");
	a_count_write: assert property (wr && op == 8'hE8 && lastw == 8'hE8 && d != 8'hE8
		|-> rdy && o_flash_addr == opa && o_flash_dq_out[15:8] == 8'h00)
		else $error("count written without availability or off start");
	a_array_exit: assert property ($fell(o_busy) && wcnt > 4'h1
		|-> lastw == CMD_READ_ARRAY)
		else $error("operation ended without read array command");
endmodule : fcs_sequencer_monitor

bind fcs_sequencer fcs_sequencer_monitor u_fcs_sequencer_monitor (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_flash_addr(o_flash_addr),
	.o_flash_dq_out(o_flash_dq_out), .o_flash_dq_oe(o_flash_dq_oe),
	.i_flash_dq_in(i_flash_dq_in), .o_flash_ce_n(o_flash_ce_n),
	.o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n), .o_busy(o_busy)
);

`default_nettype wire

/* File: bench/fcs_sequencer_tb.sv */
// self-checking bench: apb register tasks driving the sequencer into a flash model
// assumes the design's one-wait-state apb slave and the package register map
`default_nettype none

module fcs_sequencer_tb
	import fcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary clear code, shared by design and model
	localparam logic [7:0] CLR = 8'h5A;
	logic i_mclk = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic vpp_bad = 1'b0, fail = 1'b0, pready, pslverr, perr, dq_oe, ce_n, we_n, oe_n, busy;
	logic [PADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, st, r;
	logic [ADDR_W-1:0] faddr;
	logic [DATA_W-1:0] dq_out, f_dq;
	wire logic [DATA_W-1:0] dq = dq_oe ? dq_out : f_dq;
	int error_cnt = 0, check_count = 0;

	fcs_sequencer #(.P_CMD_CLEAR_STATUS(CLR)) u_fcs_sequencer (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_flash_addr(faddr), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe),
		.i_flash_dq_in(dq), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n),
		.o_busy(busy));
	fcs_flash_model #(.P_CLR(CLR)) u_fcs_flash_model (.i_mclk(i_mclk), .i_ce_n(ce_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_addr(faddr), .i_dq(dq), .i_vpp_bad(vpp_bad),
		.i_fail(fail), .o_dq(f_dq));

	initial forever #5 i_mclk = ~i_mclk;

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic guard(input int n, input int lim);
		if (n >= lim) begin
			chk(32'h0000_0000, 32'h0000_0001);
			report_and_stop();
		end
	endtask : guard

	task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge i_mclk);
		penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		{r, perr} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		guard(n, 50);
	endtask : apb

	task automatic op(input logic [2:0] code, input logic [20:0] a, input logic [15:0] d,
			input logic alt);
		int n;
		n = 0;
		apb(1'b1, REG_ADDR, {11'h000, a});
		apb(1'b1, REG_WDATA, {16'h0000, d});
		apb(1'b1, REG_CTRL, {23'h00_0000, 1'b1, 4'h0, alt, code});
		do begin
			apb(1'b0, REG_STATUS, '0);
			n++;
		end while (r[0] !== 1'b0 && n < 3000);
		st = r;
		guard(n, 3000);
		chk({31'h0000_0000, st[1]}, 32'h0000_0001);
	endtask : op

	task automatic sts(input logic [7:0] exp);
		chk({24'h00_0000, st[15:8]}, {24'h00_0000, exp});
	endtask : sts

	task automatic rd_arr(input logic [20:0] a, input logic [15:0] exp);
		op(OP_READ_ARRAY, a, 16'h0000, 1'b0);
		apb(1'b0, REG_RDATA, '0);
		chk(r, {16'h0000, exp});
	endtask : rd_arr

	task automatic buf_fill(input logic [31:0] base);
		apb(1'b1, REG_COUNT, 32'h0000_0003);
		for (int i = 0; i < 4; i++) apb(1'b1, 12'h040 + 12'(4 * i), base + i);
	endtask : buf_fill

	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		chk({27'h000_0000, ce_n, we_n, oe_n, dq_oe, busy}, 32'h0000_001C);
		apb(1'b0, 12'h020, '0);
		chk({31'h0000_0000, perr}, 32'h0000_0001);
		op(OP_WORD_WRITE, 21'h0_0010, 16'h1234, 1'b0);
		sts(8'h80);
		op(OP_WORD_WRITE, 21'h0_0011, 16'hA5A5, 1'b1);
		rd_arr(21'h0_0010, 16'h1234);
		rd_arr(21'h0_0011, 16'hA5A5);
		buf_fill(32'h0000_B000);
		op(OP_BUF_WRITE, 21'h0_0020, 16'h0000, 1'b0);
		chk({24'h00_0000, st[31:24]}, 32'h0000_0080);
		for (int i = 0; i < 4; i++) rd_arr(21'h0_0020 + 21'(i), 16'hB000 + 16'(i));
		op(OP_LOCK_SET, 21'h1_0000, 16'h0000, 1'b0);
		op(OP_WORD_WRITE, 21'h1_0005, 16'h0000, 1'b0);
		sts(8'h82);
		op(OP_BLOCK_ERASE, 21'h0_0010, 16'h0000, 1'b0);
		sts(8'h82);
		rd_arr(21'h0_0011, 16'hFFFF);
		fail <= 1'b1;
		op(OP_BANK_ERASE, 21'h0_0000, 16'h0000, 1'b0);
		sts(8'hA2);
		fail <= 1'b0;
		op(OP_CLEAR_STATUS, 21'h0_0000, 16'h0000, 1'b0);
		op(OP_READ_STATUS, 21'h0_0000, 16'h0000, 1'b0);
		sts(8'h80);
		vpp_bad <= 1'b1;
		op(OP_WORD_WRITE, 21'h0_0030, 16'h00FF, 1'b0);
		sts(8'h98);
		{vpp_bad, fail} <= 2'h1;
		op(OP_CLEAR_STATUS, 21'h0_0000, 16'h0000, 1'b0);
		op(OP_WORD_WRITE, 21'h0_0031, 16'h00FF, 1'b0);
		sts(8'h90);
		fail <= 1'b0;
		op(OP_CLEAR_STATUS, 21'h0_0000, 16'h0000, 1'b0);
		buf_fill(32'h0000_C000);
		op(OP_BUF_WRITE, 21'h0_FFFE, 16'h0000, 1'b0);
		chk({31'h0000_0000, st[16]}, 32'h0000_0001);
		op(OP_READ_STATUS, 21'h0_0000, 16'h0000, 1'b0);
		sts(8'h80);
		rd_arr(21'h0_FFFE, 16'hFFFF);
		report_and_stop();
	end
endmodule : fcs_sequencer_tb

`default_nettype wire
